/* File: shared/emac_fc_pkg.sv */
// Package for the MAC flow-control and configuration block.
// Assumes one 50 MHz clock and a plain strobe register port.
package emac_fc_pkg;

   // Register word indices (byte address = index * 4)
   localparam logic [3:0] OFF_CTRL_ONE   = 4'h0;
   localparam logic [3:0] OFF_CFG_TWO    = 4'h4;
   localparam logic [3:0] OFF_STATUS     = 4'h8;
   localparam logic [3:0] OFF_PAUSE_TMR  = 4'hc;
   localparam logic [3:0] OFF_WATERMARK  = 4'h1;
   localparam logic [3:0] OFF_CFG_SET    = 4'h5;
   localparam logic [3:0] OFF_CFG_CLR    = 4'h6;
   localparam logic [3:0] OFF_CFG_INV    = 4'h7;

   // Control-one bit positions
   localparam int BIT_AUTO_FC  = 7;
   localparam int BIT_MAN_FC   = 4;
   localparam int BIT_BUF_DEC  = 0;

   // Config-two bit positions
   localparam int BIT_EXCESS_DEFER = 14;
   localparam int BIT_BP_NO_BKOFF  = 13;
   localparam int BIT_NO_BKOFF     = 12;
   localparam int BIT_LONG_PRE     = 9;
   localparam int BIT_PURE_PRE     = 8;
   localparam int BIT_AUTO_PAD     = 7;
   localparam int BIT_VLAN_PAD     = 6;
   localparam int BIT_PAD_EN       = 5;

   // Reset values and writable mask of config-two
   localparam logic [31:0] CFG_TWO_RST  = 32'h0000_40b2;
   localparam logic [31:0] CFG_TWO_MASK = 32'h0000_73ff;

   // Access sizes
   localparam logic [1:0] SIZE_8  = 2'h0;
   localparam logic [1:0] SIZE_16 = 2'h1;
   localparam logic [1:0] SIZE_32 = 2'h2;

   // Frame constants
   localparam logic [7:0]  PREAMBLE_OCTET = 8'h55;
   localparam logic [15:0] VLAN_TPID      = 16'h8100;
   localparam logic [15:0] PAUSE_OPCODE   = 16'h0001;
   localparam logic [15:0] MAC_CTRL_TYPE  = 16'h8808;
   localparam logic [47:0] PAUSE_DA       = 48'h0180_c200_0001;
   localparam int          LONG_PRE_LIMIT = 12;

   // Pause repeat: 128 * timer / 2 tx-clock cycles
   localparam int          PAUSE_QUANTA_HALF = 64;

   // System and transmit clock rates, in kHz, and system cycles per tx clock
   localparam int CLK_KHZ       = 50000;
   localparam int TXCLK_10M_KHZ = 2500;
   localparam int TXCLK_100M_KHZ = 25000;
   localparam logic [4:0] DIV_10M  = 5'(CLK_KHZ / TXCLK_10M_KHZ);
   localparam logic [4:0] DIV_100M = 5'(CLK_KHZ / TXCLK_100M_KHZ);

   // Register bus request
   typedef struct packed {
      logic [3:0]  addr;
      logic [31:0] wdata;
      logic [1:0]  size;
      logic        wr;
      logic        rd;
   } reg_req_t;

   // Pause frame request handed to the transmitter
   typedef struct packed {
      logic [47:0] dest;
      logic [15:0] ethertype;
      logic [15:0] opcode;
      logic [15:0] pause_time;
   } pause_frame_t;

   // Flow-control state
   typedef enum logic [3:0] {
      FC_IDLE  = 4'b0001,
      FC_SEND  = 4'b0010,
      FC_WAIT  = 4'b0100,
      FC_STOP  = 4'b1000
   } fc_state_t;

endpackage

/* File: src/emac_fc_cfg.sv */
// MAC flow-control and configuration registers with pause generation.
// Assumes synchronous inputs on i_clk and a strobe register port.
//
// Chosen here: the placing of the registers and the strobed register port.
`timescale 1ns/10ps
// Operation
// - Auto mode: flow control on at full mark, off at empty mark
// - Manual mode: pause frame with timer, resent every 128*timer/2 tx clocks
// - Clearing manual mode sends one pause frame with zero timer
// - Tx clock is 2.5 MHz at 10 Mbps, 25 MHz at 100 Mbps
// - Decrement bit reads zero; writing one lowers buffer count by one
// - Receive increment together with decrement leaves count unchanged
// - Excess defer set: defer forever; clear: abort at deferral limit
// - Backpressure no-backoff: retransmit at once after own backpressure hit
// - No-backoff set: retransmit at once after any collision
// - Long preamble enforce: accept only preambles under 12 bytes
// - Pure preamble enforce: every octet 0x55, else discard
// - Auto pad detect compares octets after source with 0x8100
// - Auto pad and VLAN pad ignored while pad enable is clear
// - Config register and aliases take 16/32-bit access, ignore 8-bit (here only 8-bit writes are ignored; reads return data at any size)
// - Flow control acts on transmit and receive paths
module emac_fc_cfg #(
   parameter int CNT_W  = 8,
   parameter int FIFO_D = 8
) (
   // Clock and reset
   input  wire logic                   i_clk,
   input  wire logic                   i_sys_rst,
   // Register port
   input  wire emac_fc_pkg::reg_req_t  i_req,
   output      logic [31:0]            o_rdata,
   // Receive path events
   input  wire logic                   i_rx_buf_inc,
   input  wire logic                   i_speed_100,
   input  wire logic                   i_pre_octet_valid,
   input  wire logic [7:0]             i_pre_octet,
   input  wire logic                   i_pre_end,
   input  wire logic                   i_len_type_valid,
   input  wire logic [15:0]            i_len_type,
   // Transmit path events
   input  wire logic                   i_collision,
   input  wire logic                   i_backpressure,
   input  wire logic                   i_defer_limit,
   // Pause frame stream
   output      logic                   o_pause_valid,
   output      emac_fc_pkg::pause_frame_t o_pause_frame,
   input  wire logic                   i_pause_ready,
   // Status toward the MAC paths
   output      logic                   o_flow_ctrl_on,
   output      logic                   o_tx_abort,
   output      logic                   o_skip_backoff,
   output      logic                   o_rx_discard,
   output      logic                   o_pad_vlan,
   output      logic                   o_pad_plain
);
   import emac_fc_pkg::*;

   typedef struct packed {
      logic                 auto_fc;
      logic                 man_fc;
      logic [31:0]          cfg;
      logic [15:0]          ptimer;
      logic [CNT_W-1:0]     full_mark;
      logic [CNT_W-1:0]     empty_mark;
      logic [CNT_W-1:0]     buf_cnt;
      logic                 auto_on;
      fc_state_t            st;
      logic                 send_zero;
      logic [22:0]          rpt_cnt;
      logic [4:0]           div_cnt;
      logic [4:0]           pre_len;
      logic                 pre_bad;
      logic                 fifo_push;
      logic [15:0]          push_time;
      logic [31:0]          rdata;
      logic                 fc_on;
      logic                 tx_abort;
      logic                 skip_bo;
      logic                 rx_discard;
      logic                 pad_vlan;
      logic                 pad_plain;
      logic                 pause_valid;
      pause_frame_t         pause_frame;
   } state_t;

   state_t s_q;
   state_t s_d;

   logic         fifo_ready;
   logic         fifo_ovalid;
   pause_frame_t fifo_odata;

   initial begin
      if (CNT_W < 1 || CNT_W > 8) $error("CNT_W must be 1..8");
   end

   // Size check: byte writes are dropped
   function automatic logic size_ok(input logic [1:0] sz);
      return (sz == SIZE_16) || (sz == SIZE_32);
   endfunction

   // Write data limited by access size
   function automatic logic [31:0] wmask(input logic [1:0] sz);
      return (sz == SIZE_32) ? 32'hffff_ffff : 32'h0000_ffff;
   endfunction

   // Pause frame builder
   function automatic pause_frame_t mk_pause(input logic [15:0] t);
      pause_frame_t f;
      f.dest       = PAUSE_DA;
      f.ethertype  = MAC_CTRL_TYPE;
      f.opcode     = PAUSE_OPCODE;
      f.pause_time = t;
      return f;
   endfunction

   // Next-state logic
   always_comb begin
      logic wr;
      logic rd;
      logic dec;
      logic tx_tick;
      logic [31:0] wd;
      logic [31:0] rpt_len;
      wr = i_req.wr && size_ok(i_req.size);
      rd = i_req.rd;
      wd = i_req.wdata & wmask(i_req.size);
      // tx tick and repeat length in tx clocks
      tx_tick = (s_q.div_cnt == 5'h0);
      rpt_len = 32'(s_q.ptimer) * 32'(PAUSE_QUANTA_HALF);
      s_d = s_q;
      s_d.fifo_push = 1'b0;
      dec = 1'b0;
      if (wr) begin
         unique case (i_req.addr)
            OFF_CTRL_ONE: begin
               s_d.auto_fc = wd[BIT_AUTO_FC];
               s_d.man_fc  = wd[BIT_MAN_FC];
               dec         = wd[BIT_BUF_DEC];
            end
            OFF_CFG_TWO: s_d.cfg = wd & CFG_TWO_MASK;
            OFF_CFG_SET: s_d.cfg = (s_q.cfg | wd) & CFG_TWO_MASK;
            OFF_CFG_CLR: s_d.cfg = s_q.cfg & ~wd;
            OFF_CFG_INV: s_d.cfg = (s_q.cfg ^ wd) & CFG_TWO_MASK;
            OFF_PAUSE_TMR: s_d.ptimer = wd[15:0];
            OFF_WATERMARK: begin
               s_d.full_mark  = wd[CNT_W-1:0];
               s_d.empty_mark = wd[8 +: CNT_W];
            end
            default: ;
         endcase
      end
      if (dec && !i_rx_buf_inc) s_d.buf_cnt = s_q.buf_cnt - 1'b1;
      else if (i_rx_buf_inc && !dec) s_d.buf_cnt = s_q.buf_cnt + 1'b1;
      if (!s_q.auto_fc) s_d.auto_on = 1'b0;
      else if (s_q.buf_cnt >= s_q.full_mark) s_d.auto_on = 1'b1;
      else if (s_q.buf_cnt <= s_q.empty_mark) s_d.auto_on = 1'b0;
      // tx clock tick from system clock
      s_d.div_cnt = tx_tick ? ((i_speed_100 ? DIV_100M : DIV_10M) - 5'h1)
                            : s_q.div_cnt - 5'h1;
      unique case (s_q.st)
         FC_IDLE: if (s_q.man_fc) s_d.st = FC_SEND;
         FC_SEND: if (fifo_ready) begin
            s_d.fifo_push = 1'b1;
            s_d.push_time = s_q.ptimer;
            s_d.rpt_cnt   = '0;
            s_d.st        = FC_WAIT;
         end
         FC_WAIT: begin
            if (!s_q.man_fc) s_d.st = FC_STOP;
            else if (tx_tick) begin
               s_d.rpt_cnt = s_q.rpt_cnt + 23'h1;
               if (32'(s_q.rpt_cnt) + 32'h1 >= rpt_len) s_d.st = FC_SEND;
            end
         end
         FC_STOP: if (fifo_ready) begin
            s_d.fifo_push = 1'b1;
            s_d.push_time = 16'h0000;
            s_d.st        = FC_IDLE;
         end
      endcase
      if (i_pre_octet_valid) begin
         if (s_q.pre_len != 5'h1f) s_d.pre_len = s_q.pre_len + 5'h1;
         if (i_pre_octet != PREAMBLE_OCTET) s_d.pre_bad = 1'b1;
      end
      s_d.rx_discard = 1'b0;
      if (i_pre_end) begin
         s_d.rx_discard =
            (s_q.cfg[BIT_LONG_PRE] && s_q.pre_len >= 5'(LONG_PRE_LIMIT)) ||
            (s_q.cfg[BIT_PURE_PRE] && s_q.pre_bad);
         s_d.pre_len = '0;
         s_d.pre_bad = 1'b0;
      end
      if (i_len_type_valid) begin
         s_d.pad_vlan  = s_q.cfg[BIT_PAD_EN] &&
            ((s_q.cfg[BIT_AUTO_PAD] && i_len_type == VLAN_TPID) ||
             (!s_q.cfg[BIT_AUTO_PAD] && s_q.cfg[BIT_VLAN_PAD]));
         s_d.pad_plain = s_q.cfg[BIT_PAD_EN] && !s_d.pad_vlan;
      end
      s_d.tx_abort = i_defer_limit && !s_q.cfg[BIT_EXCESS_DEFER];
      s_d.skip_bo = i_collision && (s_q.cfg[BIT_NO_BKOFF] ||
                    (i_backpressure && s_q.cfg[BIT_BP_NO_BKOFF]));
      s_d.fc_on = s_d.auto_on || s_d.man_fc;
      // output stage refills only when empty or taken
      if (!s_q.pause_valid || i_pause_ready) begin
         s_d.pause_valid = fifo_ovalid;
         s_d.pause_frame = fifo_odata;
      end
      // Read data, decrement bit reads as zero
      s_d.rdata = '0;
      if (rd) begin
         unique case (i_req.addr)
            OFF_CTRL_ONE: begin
               s_d.rdata[BIT_AUTO_FC] = s_q.auto_fc;
               s_d.rdata[BIT_MAN_FC]  = s_q.man_fc;
            end
            OFF_CFG_TWO, OFF_CFG_SET, OFF_CFG_CLR, OFF_CFG_INV:
               s_d.rdata = s_q.cfg;
            OFF_STATUS: s_d.rdata[16 +: CNT_W] = s_q.buf_cnt;
            OFF_PAUSE_TMR: s_d.rdata[15:0] = s_q.ptimer;
            OFF_WATERMARK: begin
               s_d.rdata[CNT_W-1:0]  = s_q.full_mark;
               s_d.rdata[8 +: CNT_W] = s_q.empty_mark;
            end
            default: s_d.rdata = '0;
         endcase
      end
   end

   // State register
   always_ff @(posedge i_clk) begin
      if (i_sys_rst) begin
         s_q     <= '0;
         s_q.cfg <= CFG_TWO_RST;
         s_q.st  <= FC_IDLE;
      end else begin
         s_q <= s_d;
      end
   end

   emac_fc_fifo #(
      .WIDTH ($bits(pause_frame_t)),
      .DEPTH (FIFO_D)
   ) u_fifo (
      .i_clk       (i_clk),
      .i_sys_rst   (i_sys_rst),
      .i_in_valid  (s_q.fifo_push),
      .i_in_data   (mk_pause(s_q.push_time)),
      .o_in_ready  (fifo_ready),
      .o_out_valid (fifo_ovalid),
      .o_out_data  (fifo_odata),
      .i_out_ready (!s_q.pause_valid || i_pause_ready)
   );

   // Registered outputs
   assign o_rdata        = s_q.rdata;
   assign o_flow_ctrl_on = s_q.fc_on;
   assign o_tx_abort     = s_q.tx_abort;
   assign o_skip_backoff = s_q.skip_bo;
   assign o_rx_discard   = s_q.rx_discard;
   assign o_pad_vlan     = s_q.pad_vlan;
   assign o_pad_plain    = s_q.pad_plain;
   assign o_pause_valid  = s_q.pause_valid;
   assign o_pause_frame  = s_q.pause_frame;

   property p_dec;
      @(posedge i_clk) disable iff (i_sys_rst)
      (i_req.wr && size_ok(i_req.size) && i_req.addr == OFF_CTRL_ONE &&
       i_req.wdata[BIT_BUF_DEC] && !i_rx_buf_inc)
      |=> s_q.buf_cnt == $past(s_q.buf_cnt) - 1'b1;
   endproperty
   a_dec: assert property (p_dec) else $error("decrement lost");
   property p_both;
      @(posedge i_clk) disable iff (i_sys_rst)
      (i_req.wr && size_ok(i_req.size) && i_req.addr == OFF_CTRL_ONE &&
       i_req.wdata[BIT_BUF_DEC] && i_rx_buf_inc) |=> $stable(s_q.buf_cnt);
   endproperty
   a_both: assert property (p_both) else $error("count moved");
   property p_byte;
      @(posedge i_clk) disable iff (i_sys_rst)
      (i_req.wr && i_req.size == SIZE_8) |=> $stable(s_q.cfg);
   endproperty
   a_byte: assert property (p_byte) else $error("byte write taken");
   property p_zero;
      @(posedge i_clk) disable iff (i_sys_rst)
      (s_q.st == FC_STOP && fifo_ready) |=>
         s_q.fifo_push && s_q.push_time == 16'h0000;
   endproperty
   a_zero: assert property (p_zero) else $error("no zero pause");
   property p_abort;
      @(posedge i_clk) disable iff (i_sys_rst)
      o_tx_abort |-> $past(i_defer_limit) && !$past(s_q.cfg[BIT_EXCESS_DEFER]);
   endproperty
   a_abort: assert property (p_abort) else $error("bad abort");
   property p_pad;
      @(posedge i_clk) disable iff (i_sys_rst)
      (i_len_type_valid && !s_q.cfg[BIT_PAD_EN]) |=> !o_pad_vlan;
   endproperty
   a_pad: assert property (p_pad) else $error("pad without enable");
   // auto flow control at full mark
   property p_full;
      @(posedge i_clk) disable iff (i_sys_rst)
      (s_q.auto_fc && s_q.buf_cnt >= s_q.full_mark) |=> o_flow_ctrl_on;
   endproperty
   a_full: assert property (p_full) else $error("no auto flow");
   property p_pure;
      @(posedge i_clk) disable iff (i_sys_rst)
      (i_pre_end && s_q.pre_bad && s_q.cfg[BIT_PURE_PRE]) |=> o_rx_discard;
   endproperty
   a_pure: assert property (p_pure) else $error("bad preamble kept");
   // timer value carried in repeated frame
   property p_ptime;
      @(posedge i_clk) disable iff (i_sys_rst)
      (s_q.st == FC_SEND && fifo_ready) |=>
         s_q.fifo_push && s_q.push_time == $past(s_q.ptimer);
   endproperty
   a_ptime: assert property (p_ptime) else $error("pause time lost");
   property p_skip;
      @(posedge i_clk) disable iff (i_sys_rst)
      o_skip_backoff |-> $past(i_collision) &&
         ($past(s_q.cfg[BIT_NO_BKOFF]) ||
          ($past(i_backpressure) && $past(s_q.cfg[BIT_BP_NO_BKOFF])));
   endproperty
   a_skip: assert property (p_skip) else $error("bad backoff skip");
   property p_man;
      @(posedge i_clk) disable iff (i_sys_rst)
      $rose(s_q.man_fc) |-> o_flow_ctrl_on;
   endproperty
   a_man: assert property (p_man) else $error("manual flow off");
   // frame held while the sink stalls
   property p_hold;
      @(posedge i_clk) disable iff (i_sys_rst)
      (o_pause_valid && !i_pause_ready) |=>
         o_pause_valid && $stable(o_pause_frame);
   endproperty
   a_hold: assert property (p_hold) else $error("frame dropped");

   c_pause: cover property (@(posedge i_clk) o_pause_valid && i_pause_ready);
   c_drop:  cover property (@(posedge i_clk) o_rx_discard);
   c_stop:  cover property (@(posedge i_clk) s_q.st == FC_STOP);
   c_auto:  cover property (@(posedge i_clk) $rose(s_q.auto_on));
endmodule

/* File: src/emac_fc_fifo.sv */
// Small synchronous FIFO carrying pause frame requests.
// Assumes one clock and a synchronous active-high reset.
`timescale 1ns/10ps
module emac_fc_fifo #(
   parameter int WIDTH = 96,
   parameter int DEPTH = 8
) (
   // Clock and reset
   input  wire logic             i_clk,
   input  wire logic             i_sys_rst,
   // Fill side
   input  wire logic             i_in_valid,
   input  wire logic [WIDTH-1:0] i_in_data,
   output      logic             o_in_ready,
   // Drain side
   output      logic             o_out_valid,
   output      logic [WIDTH-1:0] o_out_data,
   input  wire logic             i_out_ready
);
   localparam int AW = $clog2(DEPTH);

   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW-1:0]    wr_q;
   logic [AW-1:0]    rd_q;
   logic [AW:0]      cnt_q;
   logic             push;
   logic             pop;

   initial begin
      if (DEPTH < 2 || (1 << AW) != DEPTH) $error("DEPTH must be 2^n");
   end

   // Handshakes
   assign o_in_ready  = (cnt_q != (AW+1)'(DEPTH));
   assign o_out_valid = (cnt_q != '0);
   assign o_out_data  = mem[rd_q];
   assign push = i_in_valid && o_in_ready;
   assign pop  = o_out_valid && i_out_ready;

   // Pointers and storage
   always_ff @(posedge i_clk) begin
      if (i_sys_rst) begin
         wr_q  <= '0;
         rd_q  <= '0;
         cnt_q <= '0;
      end else begin
         if (push) begin
            mem[wr_q] <= i_in_data;
            wr_q      <= wr_q + 1'b1;
         end
         if (pop) rd_q <= rd_q + 1'b1;
         cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
      end
   end
endmodule

/* File: tb/emac_pause_sink.sv */
// Pause frame sink standing in for the transmit side toward the PHY.
// Assumes the block's pause stream on one clock; a stall drops ready.
`timescale 1ns/10ps
module emac_pause_sink (
   // Clock and reset
   input  wire logic                      i_clk,
   input  wire logic                      i_sys_rst,
   // Pause stream
   input  wire logic                      i_valid,
   input  wire emac_fc_pkg::pause_frame_t i_frame,
   output      logic                      o_ready,
   // Bench control
   input  wire logic                      i_stall
);
   import emac_fc_pkg::*;
   pause_frame_t frames[$];
   int           stamps[$];
   int           cyc = 0;

   // Ready follows the stall request only
   assign o_ready = !i_stall;

   // Keep every accepted frame with the cycle it was taken in
   always @(posedge i_clk) begin
      cyc++;
      if (!i_sys_rst && i_valid && o_ready) begin
         frames.push_back(i_frame);
         stamps.push_back(cyc);
      end
   end
endmodule

/* File: tb/tb_top.sv */
// Self-checking bench for the flow-control and configuration block.
// Assumes a 50 MHz clock and the pause sink model on the stream side.
`timescale 1ns/10ps
module tb_top;
   import emac_fc_pkg::*;
   logic         i_clk = 0;
   logic         i_sys_rst = 1;
   reg_req_t     req = '0;
   logic         inc = 0, sp = 1, pv = 0, pe = 0, lv = 0;
   logic         col = 0, bpr = 0, dlim = 0, stall = 0;
   logic [7:0]   po = 0;
   logic [15:0]  lt = 0;
   logic [31:0]  o_rdata;
   logic         o_pause_valid, rdy, o_flow_ctrl_on, o_tx_abort;
   logic         o_skip_backoff, o_rx_discard, o_pad_vlan, o_pad_plain;
   pause_frame_t pf;
   int           n_mismatch = 0;
   int           checked = 0;

   // Clock at 20 ns period
   always #10 i_clk = ~i_clk;

   emac_fc_cfg dut (
      .i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_req(req),
      .o_rdata(o_rdata), .i_rx_buf_inc(inc), .i_speed_100(sp),
      .i_pre_octet_valid(pv), .i_pre_octet(po), .i_pre_end(pe),
      .i_len_type_valid(lv), .i_len_type(lt), .i_collision(col),
      .i_backpressure(bpr), .i_defer_limit(dlim),
      .o_pause_valid(o_pause_valid), .o_pause_frame(pf),
      .i_pause_ready(rdy), .o_flow_ctrl_on(o_flow_ctrl_on),
      .o_tx_abort(o_tx_abort), .o_skip_backoff(o_skip_backoff),
      .o_rx_discard(o_rx_discard), .o_pad_vlan(o_pad_vlan),
      .o_pad_plain(o_pad_plain));

   emac_pause_sink sink (
      .i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_valid(o_pause_valid),
      .i_frame(pf), .o_ready(rdy), .i_stall(stall));

   // Compare and report one value
   task automatic chk(string n, logic [47:0] e, logic [47:0] g);
      checked++;
      if (g !== e) begin
         n_mismatch++;
         $display("BAD %s expected %h seen %h", n, e, g);
      end
   endtask

   // One-cycle register write
   task automatic wr(logic [3:0] a, logic [31:0] d,
                     logic [1:0] s = SIZE_32);
      @(posedge i_clk);
      req <= '{addr: a, wdata: d, size: s, wr: 1'b1, rd: 1'b0};
      @(posedge i_clk);
      req.wr <= 1'b0;
   endtask

   // Read strobe, data taken in the following cycle
   task automatic rchk(string n, logic [3:0] a, logic [31:0] e,
                       logic [31:0] m = 32'hffff_ffff);
      @(posedge i_clk);
      req <= '{addr: a, wdata: 32'h0, size: SIZE_32, wr: 1'b0, rd: 1'b1};
      @(posedge i_clk);
      req.rd <= 1'b0;
      @(negedge i_clk);
      chk(n, e & m, o_rdata & m);
   endtask

   task automatic cnt_chk(logic [7:0] e);
      rchk("rx_buffer_count", OFF_STATUS, {8'h0, e, 16'h0}, 32'h00ff_0000);
   endtask

   task automatic inc_n(int n);
      repeat (n) begin
         @(posedge i_clk);
         inc <= 1;
         @(posedge i_clk);
         inc <= 0;
      end
   endtask

   // Transmit events and the registered answers a cycle later
   task automatic tx_ev(logic c, logic b, logic d, logic ea, logic es);
      @(posedge i_clk);
      col <= c;
      bpr <= b;
      dlim <= d;
      @(posedge i_clk);
      col <= 0;
      bpr <= 0;
      dlim <= 0;
      @(negedge i_clk);
      chk("tx_abort", ea, o_tx_abort);
      chk("skip_backoff", es, o_skip_backoff);
   endtask

   // Preamble of n octets, last one spoilt when bad
   task automatic pre(int n, logic bad, logic e);
      for (int k = 0; k < n; k++) begin
         @(posedge i_clk);
         pv <= 1;
         po <= (bad && k == n - 1) ? 8'h54 : PREAMBLE_OCTET;
      end
      @(posedge i_clk);
      pv <= 0;
      pe <= 1;
      @(posedge i_clk);
      pe <= 0;
      @(negedge i_clk);
      chk("rx_discard", e, o_rx_discard);
   endtask

   task automatic pad(logic [15:0] t, logic e, logic ep);
      @(posedge i_clk);
      lv <= 1;
      lt <= t;
      @(posedge i_clk);
      lv <= 0;
      @(negedge i_clk);
      chk("pad_vlan", e, o_pad_vlan);
      chk("pad_plain", ep, o_pad_plain);
   endtask

   task automatic t_regs();
      rchk("cfg_reset", OFF_CFG_TWO, CFG_TWO_RST);
      rchk("ctrl_reset", OFF_CTRL_ONE, 32'h0);
      rchk("unmapped", 4'h3, 32'h0);
      wr(OFF_CFG_TWO, 32'h0, SIZE_8);
      rchk("cfg_byte", OFF_CFG_TWO, CFG_TWO_RST);
      wr(OFF_CFG_INV, 32'h0000_0020, SIZE_8);
      rchk("inv_byte", OFF_CFG_TWO, CFG_TWO_RST);
      wr(OFF_CFG_TWO, 32'hffff_0000, SIZE_16);
      rchk("cfg_half", OFF_CFG_TWO, 32'h0);
      wr(OFF_CFG_TWO, CFG_TWO_RST);
      wr(OFF_CFG_INV, 32'h0000_0020, SIZE_16);
      rchk("cfg_inv", OFF_CFG_TWO, 32'h0000_4092);
      wr(OFF_CFG_INV, 32'h0000_0020);
      rchk("cfg_back", OFF_CFG_TWO, CFG_TWO_RST);
   endtask

   task automatic t_count();
      inc_n(2);
      cnt_chk(8'h02);
      wr(OFF_CTRL_ONE, 32'h1);
      cnt_chk(8'h01);
      rchk("dec_reads_zero", OFF_CTRL_ONE, 32'h0);
      wr(OFF_CTRL_ONE, 32'h0);
      cnt_chk(8'h01);
      @(posedge i_clk);
      req <= '{addr: OFF_CTRL_ONE, wdata: 32'h1, size: SIZE_32,
               wr: 1'b1, rd: 1'b0};
      inc <= 1;
      @(posedge i_clk);
      req.wr <= 1'b0;
      inc <= 0;
      cnt_chk(8'h01);
   endtask

   task automatic t_auto();
      wr(OFF_WATERMARK, 32'h0000_0103);
      wr(OFF_CTRL_ONE, 32'h80);
      inc_n(1);
      @(negedge i_clk);
      chk("flow_below_full", 1'b0, o_flow_ctrl_on);
      inc_n(1);
      repeat (2) @(posedge i_clk);
      @(negedge i_clk);
      chk("flow_at_full", 1'b1, o_flow_ctrl_on);
      wr(OFF_CTRL_ONE, 32'h81);
      repeat (2) @(posedge i_clk);
      @(negedge i_clk);
      chk("flow_above_empty", 1'b1, o_flow_ctrl_on);
      wr(OFF_CTRL_ONE, 32'h81);
      repeat (2) @(posedge i_clk);
      @(negedge i_clk);
      chk("flow_at_empty", 1'b0, o_flow_ctrl_on);
      wr(OFF_CTRL_ONE, 32'h01);
      cnt_chk(8'h00);
   endtask

   // Manual pause at one speed: stall, repeat spacing, closing frame
   task automatic t_manual(logic s);
      int w;
      int gap;
      int exp_gap;
      exp_gap = (128 * 2 / 2) * (s ? 50000 / 25000 : 50000 / 2500);
      @(posedge i_clk);
      sp <= s;
      stall <= 1;
      sink.frames.delete();
      sink.stamps.delete();
      wr(OFF_PAUSE_TMR, 32'h2);
      wr(OFF_CTRL_ONE, 32'h10);
      repeat (30) @(posedge i_clk);
      chk("valid_held", 1'b1, o_pause_valid);
      stall <= 0;
      w = 0;
      while (sink.frames.size() < 3 && w < 8000) begin
         @(posedge i_clk);
         w++;
      end
      chk("frames", 3, sink.frames.size());
      chk("pause_time", 16'h2, sink.frames[0].pause_time);
      chk("dest", PAUSE_DA, sink.frames[0].dest);
      chk("type", MAC_CTRL_TYPE, sink.frames[0].ethertype);
      chk("opcode", PAUSE_OPCODE, sink.frames[0].opcode);
      chk("manual_flow", 1'b1, o_flow_ctrl_on);
      gap = sink.stamps[2] - sink.stamps[1];
      if (gap < exp_gap - 4 || gap > exp_gap + 4)
         chk("repeat_gap", exp_gap, gap);
      w = sink.frames.size();
      wr(OFF_CTRL_ONE, 32'h0);
      repeat (100) @(posedge i_clk);
      chk("stop_frame", 16'h0, sink.frames[$].pause_time);
      chk("no_repeat", 1, sink.frames.size() - w);
      chk("manual_off", 1'b0, o_flow_ctrl_on);
   endtask

   task automatic t_tx();
      tx_ev(0, 0, 1, 0, 0);
      wr(OFF_CFG_CLR, 32'h0000_4000);
      tx_ev(0, 0, 1, 1, 0);
      tx_ev(1, 0, 0, 0, 0);
      wr(OFF_CFG_SET, 32'h0000_1000);
      tx_ev(1, 0, 0, 0, 1);
      wr(OFF_CFG_CLR, 32'h0000_1000);
      wr(OFF_CFG_SET, 32'h0000_2000);
      tx_ev(1, 1, 0, 0, 1);
      tx_ev(1, 0, 0, 0, 0);
      wr(OFF_CFG_TWO, CFG_TWO_RST);
   endtask

   task automatic t_rx();
      pre(7, 1, 0);
      wr(OFF_CFG_SET, 32'h0000_0100);
      pre(7, 0, 0);
      pre(7, 1, 1);
      wr(OFF_CFG_CLR, 32'h0000_0100);
      pre(12, 0, 0);
      wr(OFF_CFG_SET, 32'h0000_0200);
      pre(11, 0, 0);
      pre(12, 0, 1);
      wr(OFF_CFG_TWO, CFG_TWO_RST);
      pad(VLAN_TPID, 1, 0);
      pad(16'h0800, 0, 1);
      wr(OFF_CFG_CLR, 32'h0000_0020);
      wr(OFF_CFG_SET, 32'h0000_0040);
      pad(VLAN_TPID, 0, 0);
   endtask

   task automatic end_of_test();
      if (n_mismatch == 0 && checked > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask

   // Main sequence after four cycles of reset
   initial begin
      repeat (4) @(posedge i_clk);
      i_sys_rst <= 0;
      t_regs();
      t_count();
      t_auto();
      t_manual(1'b1);
      t_manual(1'b0);
      t_tx();
      t_rx();
      end_of_test();
   end

   // Watchdog well past the longest expected run
   initial begin
      repeat (60000) @(posedge i_clk);
      n_mismatch++;
      end_of_test();
   end
endmodule
